// ===== rtl/motion_event_pkg.sv
// Shared constants and types of the motion event control block
package motion_event_pkg;

	// ****************************************
	// Register offsets and reset values
	// ****************************************
	localparam logic [7:0] OFS_OP_STATE    = 8'h07;  // Operating-state control
	localparam logic [7:0] OFS_TAP_ENABLE  = 8'h09;  // Tap axis enables
	localparam logic [7:0] OFS_TAP_COUNT   = 8'h0A;  // Tap pulse count
	localparam logic [7:0] OFS_DROP_CTRL   = 8'h0B;  // Drop event control
	localparam logic [7:0] OFS_SHAKE_COUNT = 8'h0C;  // Shake debounce count
	localparam logic [7:0] RST_OP_STATE    = 8'h03;  // STANDBY after reset
	localparam logic [7:0] RST_TAP_ENABLE  = 8'h00;
	localparam logic [7:0] RST_TAP_COUNT   = 8'h00;
	localparam logic [7:0] RST_DROP_CTRL   = 8'h00;
	localparam logic [7:0] RST_SHAKE_COUNT = 8'h00;

	// ****************************************
	// Field positions and widths
	// ****************************************
	localparam int OPSEL_LSB      = 0;  // State select, two bits
	localparam int IRQ_PP_BIT     = 6;  // Interrupt pin push-pull
	localparam int IRQ_AH_BIT     = 7;  // Interrupt pin active high
	localparam int TAP_EN_LSB     = 5;  // X at 5, Y at 6, Z at 7
	localparam int TAP_CNT_LSB    = 0;
	localparam int TAP_CNT_W      = 4;
	localparam int DROP_DEBOUNCE_LSB    = 0;
	localparam int DROP_DEBOUNCE_W      = 3;
	localparam int DROP_IRQ_BIT   = 6;
	localparam int DROP_MODE_BIT  = 7;
	localparam int SHAKE_DB_LSB   = 0;
	localparam int SHAKE_DB_W     = 6;

	// ****************************************
	// Codes and counts
	// ****************************************
	localparam logic [1:0] OPSEL_WAKE    = 2'h1;  // Move to WAKE
	localparam logic [1:0] OPSEL_STANDBY = 2'h3;  // Move to STANDBY
	localparam int         RUN_W         = 7;     // Run-length counter width
	localparam int         MAG_W         = 14;    // Axis magnitude width
	localparam int         SYNC_N        = 3;     // Crossing events: write, access, read

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_STANDBY = 2'b01,
		ST_WAKE    = 2'b10
	} op_state_e;

	typedef struct packed {
		logic [MAG_W-1:0] z;
		logic [MAG_W-1:0] y;
		logic [MAG_W-1:0] x;
	} axis_mag_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_s;

endpackage

// ===== rtl/link_reg_port.sv
// Link-clock side of the register port: holds writes and toggles events
`timescale 1ns/1ps
module link_reg_port (
	input  wire logic                           i_link_clock,
	input  wire logic                           i_reset_n,
	input  wire logic                           i_wr_strobe,
	input  wire logic [7:0]                     i_wr_addr,
	input  wire logic [7:0]                     i_wr_data,
	input  wire logic                           i_access_strobe,
	input  wire logic                           i_status_read_strobe,
	output motion_event_pkg::reg_write_s        o_wr_hold,
	output logic [motion_event_pkg::SYNC_N-1:0] o_toggle
);

	// ****************************************
	// Event capture
	// ****************************************
	// Each event flips its toggle; the write word stays put until the next
	// write so the core can sample it after the toggle has been synchronised
	always_ff @(posedge i_link_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_wr_hold <= '0;
			o_toggle  <= '0;
		end else begin
			if (i_wr_strobe) begin
				o_wr_hold <= '{addr: i_wr_addr, data: i_wr_data};
			end
			o_toggle <= o_toggle ^ {i_status_read_strobe, i_access_strobe, i_wr_strobe};
		end
	end

endmodule

// ===== rtl/event_debounce.sv
// Run-length qualifier for one detection stream, counted per sample
`timescale 1ns/1ps
module event_debounce #(
	parameter int RUN_W = 7
) (
	input  wire logic             i_clock,
	input  wire logic             i_reset_n,
	input  wire logic             i_sample,
	input  wire logic             i_detect,
	input  wire logic [RUN_W-1:0] i_target,
	output logic                  o_reach,
	output logic                  o_end_exact
);

	logic [RUN_W-1:0] run_q;  // Adjacent detections so far
	logic [RUN_W-1:0] run_d;
	wire              run_full = &run_q;  // Saturate so long runs stay long

	// Next run length: clear on a miss, count up on a hit
	assign run_d = !i_detect ? '0 : (run_full ? run_q : RUN_W'(run_q + 1'b1));

	// ****************************************
	// Counter and qualification pulses
	// ****************************************
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_q       <= '0;
			o_reach     <= 1'b0;
			o_end_exact <= 1'b0;
		end else begin
			o_reach     <= 1'b0;
			o_end_exact <= 1'b0;
			if (i_sample) begin
				run_q       <= run_d;
				o_reach     <= i_detect && (run_d == i_target);
				o_end_exact <= !i_detect && (run_q != '0) && (run_q == i_target);
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	exact_pulse_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		o_end_exact |-> run_q == '0 && $past(run_q) == $past(i_target))
		else $error("Pulse end accepted with wrong run length");
	reach_count_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		o_reach |-> run_q == $past(i_target))
		else $error("Debounce reached at wrong count");

endmodule

// ===== rtl/motion_event_control.sv
// Motion event control: operating state, interrupt pin and event qualifiers
`timescale 1ns/1ps
module motion_event_control #(
	parameter logic [motion_event_pkg::MAG_W-1:0] HALF_G = 14'h0400  // Counts for 0.5g
) (
	input  wire logic                              i_clock,
	input  wire logic                              i_reset_n,
	input  wire logic                              i_link_clock,
	input  wire logic                              i_wr_strobe,
	input  wire logic [7:0]                        i_wr_addr,
	input  wire logic [7:0]                        i_wr_data,
	input  wire logic                              i_access_strobe,
	input  wire logic                              i_status_read_strobe,
	input  wire logic                              i_sample_strobe,
	input  motion_event_pkg::axis_mag_s            i_axis_mag,
	input  wire logic [motion_event_pkg::MAG_W-1:0] i_tap_threshold,
	input  wire logic [7:0]                        i_drop_threshold,
	input  wire logic [2:0]                        i_shake_detect,
	input  wire logic                              i_tap_irq_enable,
	input  wire logic [2:0]                        i_shake_irq_enable,
	output logic                                   o_irq_pin_out,
	output logic                                   o_irq_pin_oe,
	output logic [1:0]                             o_op_status,
	output logic                                   o_tap_flag,
	output logic                                   o_drop_flag,
	output logic                                   o_shake_flag
);

	localparam int RW = motion_event_pkg::RUN_W;
	localparam int MW = motion_event_pkg::MAG_W;
	localparam int SN = motion_event_pkg::SYNC_N;

	// ****************************************
	// Link side and crossing
	// ****************************************
	motion_event_pkg::reg_write_s wr_hold;   // Write word, held in link domain
	logic [SN-1:0]                toggle;    // Event toggles, link domain
	logic [SN-1:0]                sync1_q;   // First stage, read only by second
	logic [SN-1:0]                sync2_q;
	logic [SN-1:0]                sync3_q;
	wire  [SN-1:0]                ev_pulse = sync2_q ^ sync3_q;  // One-cycle events
	wire                          wr_pulse     = ev_pulse[0];
	wire                          access_pulse = ev_pulse[1];
	wire                          read_pulse   = ev_pulse[2];

	// Link-domain capture of writes and access events
	link_reg_port u_link (
		.i_link_clock         (i_link_clock),
		.i_reset_n            (i_reset_n),
		.i_wr_strobe          (i_wr_strobe),
		.i_wr_addr            (i_wr_addr),
		.i_wr_data            (i_wr_data),
		.i_access_strobe      (i_access_strobe),
		.i_status_read_strobe (i_status_read_strobe),
		.o_wr_hold            (wr_hold),
		.o_toggle             (toggle)
	);

	// Three-stage synchroniser for the event toggles
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= toggle;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ****************************************
	// Register decode
	// ****************************************
	// The write word is stable for at least one core cycle before its toggle lands
	wire wr_op    = wr_pulse && (wr_hold.addr == motion_event_pkg::OFS_OP_STATE);
	wire wr_tap   = wr_pulse && (wr_hold.addr == motion_event_pkg::OFS_TAP_ENABLE);
	wire wr_tcnt  = wr_pulse && (wr_hold.addr == motion_event_pkg::OFS_TAP_COUNT);
	wire wr_drop  = wr_pulse && (wr_hold.addr == motion_event_pkg::OFS_DROP_CTRL);
	wire wr_shake = wr_pulse && (wr_hold.addr == motion_event_pkg::OFS_SHAKE_COUNT);
	wire [1:0] opsel = wr_hold.data[motion_event_pkg::OPSEL_LSB +: 2];

	logic [7:0] op_ctrl_q;   // Operating-state control
	logic [7:0] tap_en_q;    // Tap axis enables
	logic [7:0] tap_cnt_q;   // Tap pulse count
	logic [7:0] drop_ctl_q;  // Drop event control
	logic [7:0] shake_db_q;  // Shake debounce count

	// Registers take writes whatever the operating state
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			op_ctrl_q  <= motion_event_pkg::RST_OP_STATE;
			tap_en_q   <= motion_event_pkg::RST_TAP_ENABLE;
			tap_cnt_q  <= motion_event_pkg::RST_TAP_COUNT;
			drop_ctl_q <= motion_event_pkg::RST_DROP_CTRL;
			shake_db_q <= motion_event_pkg::RST_SHAKE_COUNT;
		end else begin
			if (wr_op) begin
				op_ctrl_q <= wr_hold.data;
			end
			if (wr_tap) begin
				tap_en_q <= wr_hold.data;
			end
			if (wr_tcnt) begin
				tap_cnt_q <= wr_hold.data;
			end
			if (wr_drop) begin
				drop_ctl_q <= wr_hold.data;
			end
			if (wr_shake) begin
				shake_db_q <= wr_hold.data;
			end
		end
	end

	// ****************************************
	// Operating state
	// ****************************************
	motion_event_pkg::op_state_e op_state_q;
	motion_event_pkg::op_state_e op_state_d;
	wire wake   = (op_state_q == motion_event_pkg::ST_WAKE);
	wire sample = i_sample_strobe && wake;  // Detection runs only in WAKE

	// Reserved select codes leave the state where it is
	always_comb begin
		op_state_d = op_state_q;
		if (wr_op && opsel == motion_event_pkg::OPSEL_WAKE) begin
			op_state_d = motion_event_pkg::ST_WAKE;
		end else if (wr_op && opsel == motion_event_pkg::OPSEL_STANDBY) begin
			op_state_d = motion_event_pkg::ST_STANDBY;
		end
	end

	// ****************************************
	// Tap, drop and shake detection
	// ****************************************
	// Axis magnitudes by index so the per-axis loop can pick them
	wire [MW-1:0] mag [3];
	assign mag[0] = i_axis_mag.x;
	assign mag[1] = i_axis_mag.y;
	assign mag[2] = i_axis_mag.z;

	// Tap run must equal v plus one samples; shake count zero acts as one
	wire [RW-1:0] tap_target = RW'(tap_cnt_q[motion_event_pkg::TAP_CNT_LSB +:
		motion_event_pkg::TAP_CNT_W]) + 7'h01;
	wire [RW-1:0] drop_target = RW'(drop_ctl_q[motion_event_pkg::DROP_DEBOUNCE_LSB +:
		motion_event_pkg::DROP_DEBOUNCE_W]) + 7'h01;
	wire [motion_event_pkg::SHAKE_DB_W-1:0] shake_db =
		shake_db_q[motion_event_pkg::SHAKE_DB_LSB +: motion_event_pkg::SHAKE_DB_W];
	wire [RW-1:0] shake_target = (shake_db == 6'h00) ? 7'h01 : RW'(shake_db);

	logic [2:0] tap_end;      // Per-axis qualified tap
	logic [2:0] shake_reach;  // Per-axis debounced shake

	for (genvar a = 0; a < 3; a++) begin : g_axis
		wire tap_hit = tap_en_q[motion_event_pkg::TAP_EN_LSB + a] &&
			(mag[a] > i_tap_threshold);
		event_debounce #(.RUN_W(RW)) u_tap (
			.i_clock     (i_clock),
			.i_reset_n   (i_reset_n),
			.i_sample    (sample),
			.i_detect    (tap_hit),
			.i_target    (tap_target),
			.o_reach     (),
			.o_end_exact (tap_end[a])
		);
		event_debounce #(.RUN_W(RW)) u_shake (
			.i_clock     (i_clock),
			.i_reset_n   (i_reset_n),
			.i_sample    (sample),
			.i_detect    (i_shake_detect[a]),
			.i_target    (shake_target),
			.o_reach     (shake_reach[a]),
			.o_end_exact ()
		);
	end

	// Drop limit is 0.5g plus threshold; sum kept wide to avoid overflow
	wire [MW+1:0] mag_sum   = (MW+2)'(mag[0]) + (MW+2)'(mag[1]) + (MW+2)'(mag[2]);
	wire [MW:0]   drop_lim  = (MW+1)'(HALF_G) + (MW+1)'(i_drop_threshold);
	wire          drop_sum  = mag_sum < (MW+2)'(drop_lim);
	wire          drop_all  = ((MW+1)'(mag[0]) < drop_lim) &&
		((MW+1)'(mag[1]) < drop_lim) && ((MW+1)'(mag[2]) < drop_lim);
	wire          drop_hit  = drop_ctl_q[motion_event_pkg::DROP_MODE_BIT] ? drop_all : drop_sum;
	logic         drop_reach;

	event_debounce #(.RUN_W(RW)) u_drop (
		.i_clock     (i_clock),
		.i_reset_n   (i_reset_n),
		.i_sample    (sample),
		.i_detect    (drop_hit),
		.i_target    (drop_target),
		.o_reach     (drop_reach),
		.o_end_exact ()
	);

	// ****************************************
	// Flags and interrupt
	// ****************************************
	// A tap on any enabled axis or a shake on any axis counts as an event
	wire tap_event   = |tap_end;
	wire shake_event = |shake_reach;
	wire irq_cause   = (tap_event && i_tap_irq_enable) ||
		(drop_reach && drop_ctl_q[motion_event_pkg::DROP_IRQ_BIT]) ||
		|(shake_reach & i_shake_irq_enable);
	logic pending_q;  // Interrupt asserted, cleared by any access

	// New events win over a clear arriving in the same cycle
	wire tap_flag_d   = tap_event || (o_tap_flag && !read_pulse);
	wire drop_flag_d  = drop_reach || (o_drop_flag && !read_pulse);
	wire shake_flag_d = shake_event || (o_shake_flag && !read_pulse);
	wire pending_d    = irq_cause || (pending_q && !access_pulse);
	wire push_pull    = op_ctrl_q[motion_event_pkg::IRQ_PP_BIT];
	wire active_high  = op_ctrl_q[motion_event_pkg::IRQ_AH_BIT];
	wire pin_out_d    = active_high ? pending_q : !pending_q;
	wire pin_oe_d     = push_pull || pending_q;

	// State, flags and pin drive
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			op_state_q    <= motion_event_pkg::ST_STANDBY;
			o_op_status   <= motion_event_pkg::OPSEL_STANDBY;
			o_tap_flag    <= 1'b0;
			o_drop_flag   <= 1'b0;
			o_shake_flag  <= 1'b0;
			pending_q     <= 1'b0;
			o_irq_pin_out <= 1'b1;
			o_irq_pin_oe  <= 1'b0;
		end else begin
			op_state_q    <= op_state_d;
			o_op_status   <= wake ? motion_event_pkg::OPSEL_WAKE :
				motion_event_pkg::OPSEL_STANDBY;
			o_tap_flag    <= tap_flag_d;
			o_drop_flag   <= drop_flag_d;
			o_shake_flag  <= shake_flag_d;
			pending_q     <= pending_d;
			o_irq_pin_out <= pin_out_d;
			o_irq_pin_oe  <= pin_oe_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// All checks run on the core clock and pause during reset
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);

	op_write_a: assert property (wr_op |=> op_ctrl_q == $past(wr_hold.data))
		else $error("State control write lost");
	wake_code_a: assert property (wr_op && opsel == motion_event_pkg::OPSEL_WAKE
		|-> ##2 o_op_status == motion_event_pkg::OPSEL_WAKE)
		else $error("Wake code did not reach WAKE");
	reserved_code_a: assert property (wr_op && opsel[0] == 1'b0
		|=> op_state_q == $past(op_state_q))
		else $error("Reserved code changed state");
	push_pull_a: assert property (push_pull |=> o_irq_pin_oe)
		else $error("Push-pull pin not driven");
	open_release_a: assert property (!push_pull && !pending_q |=> !o_irq_pin_oe)
		else $error("Open-drain pin driven while idle");
	pin_level_a: assert property (pending_q |=> o_irq_pin_out == $past(active_high))
		else $error("Asserted pin level wrong");
	tap_flag_a: assert property (tap_event |=> o_tap_flag)
		else $error("Tap did not set flag");
	drop_flag_a: assert property (drop_reach |=> o_drop_flag)
		else $error("Drop did not set flag");
	irq_clear_a: assert property (access_pulse && !irq_cause |=> !pending_q)
		else $error("Access did not release interrupt");
	flag_hold_a: assert property (o_shake_flag && !read_pulse |=> o_shake_flag)
		else $error("Shake flag dropped without read");
	standby_quiet_a: assert property (!wake && !$past(wake)
		|-> ##1 (!o_drop_flag || $past(o_drop_flag)))
		else $error("Drop event raised in STANDBY");

	// Standby code, shake flag, flag clear and idle pin level
	standby_code_a: assert property (wr_op && opsel == motion_event_pkg::OPSEL_STANDBY
		|-> ##2 o_op_status == motion_event_pkg::OPSEL_STANDBY)
		else $error("Standby code did not reach STANDBY");
	shake_flag_a: assert property (shake_event |=> o_shake_flag)
		else $error("Shake did not set flag");
	flag_clear_a: assert property (read_pulse && !tap_event |=> !o_tap_flag)
		else $error("Status read did not clear tap flag");
	pin_idle_a: assert property (!pending_q |=> o_irq_pin_out == !$past(active_high))
		else $error("Idle pin level wrong");

endmodule

// ===== tb/host_link_model.sv
// Host model: register writes, bus accesses and status reads on the link clock
`timescale 1ns/1ps
module host_link_model (
	input  wire logic  i_link_clock,
	output logic       o_wr_strobe,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data,
	output logic       o_access_strobe,
	output logic       o_status_read_strobe
);
	// ****************************************
	// Bus idle at time zero
	// ****************************************
	initial begin
		o_wr_strobe          = 1'b0;
		o_wr_addr            = 8'h00;
		o_wr_data            = 8'h00;
		o_access_strobe      = 1'b0;
		o_status_read_strobe = 1'b0;
	end

	// One link cycle transfer; released lines show inverted values, not the last ones
	task automatic xfer(input logic wr, input logic rd, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge i_link_clock);
		#1;
		o_wr_strobe          = wr;
		o_status_read_strobe = rd;
		o_access_strobe      = 1'b1;
		o_wr_addr            = a;
		o_wr_data            = d;
		@(posedge i_link_clock);
		#1;
		o_wr_strobe          = 1'b0;
		o_status_read_strobe = 1'b0;
		o_access_strobe      = 1'b0;
		o_wr_addr            = ~a;
		o_wr_data            = ~d;
	endtask

	// Register write; the state register's bit 2 always goes out as zero
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, 1'b0, a, (a == motion_event_pkg::OFS_OP_STATE) ? (d & 8'hFB) : d);
	endtask

	// Plain access with no register effect
	task automatic access_only();
		xfer(1'b0, 1'b0, o_wr_addr, o_wr_data);
	endtask

	// Status register read
	task automatic read_status();
		xfer(1'b0, 1'b1, o_wr_addr, o_wr_data);
	endtask
endmodule

// ===== tb/motion_event_control_tb.sv
// Self-checking bench of the motion event control block
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp); \
	end \
end
module motion_event_control_tb;
	// ****************************************
	// Stimulus values and signals
	// ****************************************
	localparam logic [13:0] NEU = 14'h0800;  // Quiet: no tap, no drop
	localparam logic [13:0] HI  = 14'h3100;  // Above the tap threshold
	localparam logic [13:0] LOW = 14'h0100;  // Sum below the drop limit
	localparam logic [13:0] MID = 14'h0200;  // Each below limit, sum above
	localparam logic [13:0] EDG = 14'h0440;  // Each above 0.5g, below with threshold
	logic                        clock        = 1'b0;
	logic                        link_clock   = 1'b0;
	logic                        reset_n      = 1'b0;
	logic                        sample       = 1'b0;
	motion_event_pkg::axis_mag_s mag          = {NEU, NEU, NEU};
	logic [2:0]                  shake        = 3'h0;
	logic                        tap_irq_en   = 1'b0;
	logic [2:0]                  shake_irq_en = 3'h0;
	logic [7:0]                  drop_threshold      = 8'h00;
	logic                        wr_strobe, access, rd_strobe, pin_out, pin_oe;
	logic [7:0]                  wr_addr, wr_data;
	logic [1:0]                  op_status;
	logic                        tap_f, drop_f, shake_f;
	wire logic                   irq_pin_n;  // Pin level with its pull-up
	logic [1:0]                  codes [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
	logic [1:0]                  want [5]  = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h1};
	int                          counts [2] = '{3, 63};
	int                          tests_run = 0;
	int                          miscompares = 0;

	assign irq_pin_n = pin_oe ? pin_out : 1'b1;

	host_link_model host (
		.i_link_clock(link_clock), .o_wr_strobe(wr_strobe), .o_wr_addr(wr_addr),
		.o_wr_data(wr_data), .o_access_strobe(access), .o_status_read_strobe(rd_strobe)
	);

	motion_event_control uut (
		.i_clock(clock), .i_reset_n(reset_n), .i_link_clock(link_clock),
		.i_wr_strobe(wr_strobe), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
		.i_access_strobe(access), .i_status_read_strobe(rd_strobe),
		.i_sample_strobe(sample), .i_axis_mag(mag), .i_tap_threshold(14'h3000),
		.i_drop_threshold(drop_threshold), .i_shake_detect(shake), .i_tap_irq_enable(tap_irq_en),
		.i_shake_irq_enable(shake_irq_en), .o_irq_pin_out(pin_out), .o_irq_pin_oe(pin_oe),
		.o_op_status(op_status), .o_tap_flag(tap_f), .o_drop_flag(drop_f),
		.o_shake_flag(shake_f)
	);

	// Core clock, link clock out of phase, and a watchdog
	initial begin
		forever #10 clock = ~clock;
	end
	initial begin
		#37;
		forever #62.5 link_clock = ~link_clock;
	end
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		tally_and_finish();
	end

	// ****************************************
	// Helper tasks
	// ****************************************
	task automatic tally_and_finish();
		$display("Counts: %0d comparisons, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Covers the crossing latency of any link transfer
	task automatic settle();
		repeat (12) @(posedge clock);
		#1;
	endtask

	task automatic put(input logic [7:0] a, input logic [7:0] d);
		host.write_reg(a, d);
		settle();
	endtask

	task automatic clear();
		host.read_status();
		settle();
	endtask

	// One sample, then room for the flag and pin to follow
	task automatic smp(input motion_event_pkg::axis_mag_s m, input logic [2:0] sh);
		mag    = m;
		shake  = sh;
		sample = 1'b1;
		@(posedge clock);
		#1;
		sample = 1'b0;
		mag    = {NEU, NEU, NEU};
		shake  = 3'h0;
		repeat (4) @(posedge clock);
		#1;
	endtask

	// A run of len samples above the tap threshold on one axis, then a quiet one
	task automatic tap_run(input int ax, input int len);
		motion_event_pkg::axis_mag_s m;
		m = {NEU, NEU, NEU};
		m[ax*motion_event_pkg::MAG_W +: motion_event_pkg::MAG_W] = HI;
		repeat (len) smp(m, 3'h0);
		smp({NEU, NEU, NEU}, 3'h0);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clock);
		#1;
		reset_n = 1'b1;
		settle();
		`CHECK(op_status, 2'h3)
		`CHECK({irq_pin_n, pin_oe, tap_f, drop_f, shake_f}, 5'b10000)
		for (int i = 0; i < 5; i++) begin
			put(motion_event_pkg::OFS_OP_STATE, {6'h00, codes[i]});
			`CHECK(op_status, want[i])
		end
		put(8'h08, 8'h03);
		`CHECK(op_status, 2'h1)
		done("state select");

		tap_irq_en = 1'b1;
		for (int ax = 0; ax < 3; ax++) begin
			put(motion_event_pkg::OFS_TAP_ENABLE, 8'h20 << ax);
			tap_run((ax + 1) % 3, 1);
			`CHECK(tap_f, 1'b0)
			tap_run(ax, 1);
			`CHECK({tap_f, irq_pin_n, pin_oe}, 3'b101)
			host.access_only();
			settle();
			`CHECK({tap_f, irq_pin_n, pin_oe}, 3'b110)
			clear();
			`CHECK(tap_f, 1'b0)
		end
		put(motion_event_pkg::OFS_TAP_ENABLE, 8'hE0);
		for (int v = 0; v < 16; v += 15) begin
			put(motion_event_pkg::OFS_TAP_COUNT, 8'(v));
			tap_run(0, v + 2);
			`CHECK(tap_f, 1'b0)
			tap_run(0, v);
			`CHECK(tap_f, 1'b0)
			tap_run(0, v + 1);
			`CHECK(tap_f, 1'b1)
			clear();
		end
		tap_irq_en = 1'b0;
		tap_run(2, 16);
		`CHECK({tap_f, pin_oe}, 2'b10)
		clear();
		done("tap");

		put(motion_event_pkg::OFS_OP_STATE, 8'h41);
		`CHECK({pin_out, pin_oe}, 2'b11)
		put(motion_event_pkg::OFS_OP_STATE, 8'hC1);
		`CHECK({pin_out, pin_oe}, 2'b01)
		tap_irq_en = 1'b1;
		tap_run(1, 16);
		`CHECK({pin_out, pin_oe}, 2'b11)
		clear();
		put(motion_event_pkg::OFS_OP_STATE, 8'h81);
		`CHECK(pin_oe, 1'b0)
		tap_run(1, 16);
		`CHECK({irq_pin_n, pin_oe}, 2'b11)
		clear();
		put(motion_event_pkg::OFS_OP_STATE, 8'h01);
		done("interrupt pin");

		for (int v = 2; v < 8; v += 5) begin
			put(motion_event_pkg::OFS_DROP_CTRL, 8'(v));
			smp({NEU, NEU, NEU}, 3'h0);
			repeat (v) smp({LOW, LOW, LOW}, 3'h0);
			`CHECK(drop_f, 1'b0)
			smp({LOW, LOW, LOW}, 3'h0);
			`CHECK({drop_f, pin_oe}, 2'b10)
			clear();
		end
		put(motion_event_pkg::OFS_DROP_CTRL, 8'h40);
		smp({MID, MID, MID}, 3'h0);
		`CHECK(drop_f, 1'b0)
		put(motion_event_pkg::OFS_DROP_CTRL, 8'hC0);
		smp({MID, NEU, MID}, 3'h0);
		`CHECK(drop_f, 1'b0)
		smp({MID, MID, MID}, 3'h0);
		`CHECK({drop_f, irq_pin_n}, 2'b10)
		clear();
		smp({EDG, EDG, EDG}, 3'h0);
		`CHECK(drop_f, 1'b0)
		drop_threshold = 8'hFF;
		smp({EDG, EDG, EDG}, 3'h0);
		`CHECK(drop_f, 1'b1)
		clear();
		done("drop");

		shake_irq_en = 3'b010;
		for (int i = 0; i < 2; i++) begin
			put(motion_event_pkg::OFS_SHAKE_COUNT, 8'(counts[i]));
			repeat (counts[i] - 1) smp({NEU, NEU, NEU}, 3'h1 << i);
			`CHECK(shake_f, 1'b0)
			smp({NEU, NEU, NEU}, 3'h1 << i);
			`CHECK({shake_f, pin_oe}, {1'b1, i[0]})
			clear();
		end
		done("shake");
		tally_and_finish();
	end
endmodule
